// file: logic/srsc_top.sv
// Timing reference sync and reset control with Avalon-MM register slave
`timescale 1ns/1ps
`include "srsc_cfg.svh"
// What this block does
// - Sample reference pin every rising clock edge
// - Rising pin edge or soft 0-to-1 asserts
// - Reference from pins or software bit
// - Every assertion resets clock divider
// - Oscillator and multiframe reset from third assertion
// - Assertion aligns local multiframe clock boundary
// - Assertion also resets oscillators and filters
// - Programmable delay on reference input path
// - Divider mask blocks divider resets
// - Oscillator mask blocks oscillator, link resets
module srsc_top
    import srsc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        sync_ref_pin,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             divider_reset,
    output logic             oscillator_reset,
    output logic             filter_reset,
    output logic             lmfc_reset,
    output logic             lmfc_boundary
);
    // Reference pin synchroniser
    logic               pin_meta;       // First stage, read only by pin_sync
    logic               pin_sync;       // Second stage
    logic               pin_delayed;    // After the tap delay
    logic               pin_prev;       // For edge detection
    // Software visible state
    srsc_ctrl_type      ctrl;           // Control bits
    logic [3:0]         tap;            // Delay tap select
    logic [1:0]         assert_count;   // Saturating assertion count
    logic [7:0]         lmfc_count;     // Local multiframe phase counter
    logic               soft_prev;      // Previous soft assert bit
    srsc_pulse_type     pulse;          // Registered reset pulses
    srsc_bus_state_type bus_state;      // Bus answer phase
    logic               lmfc_wrap;      // Boundary flag register
    logic [31:0]        next_readdata;  // Decoded read data
    // Address match, shared by the write strobes and the read mux
    function automatic logic addr_hit(
        input logic [3:0] addr,
        input logic [3:0] want
    );
        return addr == want;
    endfunction : addr_hit
    // Decode helpers; a write lands only in the answer cycle, at the edge
    // where the master sees waitrequest low, so an early strobe changes nothing
    wire                bus_req   = (avs_read | avs_write) && (bus_state == SRSC_RESP);
    wire                wr_ctrl   = bus_req && avs_write && addr_hit(avs_address, `SRSC_ADDR_CTRL);
    wire                wr_tap    = bus_req && avs_write && addr_hit(avs_address, `SRSC_ADDR_TAP);
    // Edge and acceptance terms; the third and later assertions are late
    wire                pin_edge  = pin_delayed & ~pin_prev;
    wire                soft_edge = ctrl.sw_assert & ~soft_prev;
    wire                sync_hit  = ctrl.pin_sel ? pin_edge : soft_edge;
    wire                late_hit  = sync_hit && (assert_count >= `SRSC_CNT_LIMIT);
    wire                osc_go    = late_hit && !ctrl.osc_mask;
    wire                div_go    = sync_hit && !ctrl.div_mask;
    wire                lmfc_end  = (lmfc_count == `SRSC_LMFC_PERIOD - 8'h01);

    // Two flip-flops before the pin is looked at
    // Costs two cycles; the fixed part is folded into the tap setting
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= sync_ref_pin;
            pin_sync <= pin_meta;
        end
    end

    // Skew adjustment taps sit after the synchroniser
    // Tap 0 still adds one stage plus the output register
    srsc_delay_line u_delay (
        .clk  (clk),
        .rst  (rst),
        .din  (pin_sync),
        .tap  (tap),
        .dout (pin_delayed)
    );

    // Edge history of both sources
    // Both resets match the idle level, so no false edge follows reset
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_prev  <= 1'b0;
            soft_prev <= 1'b0;
        end else begin
            pin_prev  <= pin_delayed;
            soft_prev <= ctrl.sw_assert;
        end
    end

    // Control register; software bit is level, only its rise counts
    // Writing the bit back to 0 rearms the next software assertion
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= srsc_ctrl_type'(`SRSC_CTRL_RESET);
        end else if (wr_ctrl) begin
            ctrl <= srsc_ctrl_type'(avs_writedata[3:0]);
        end
    end

    // Tap register
    // A tap change mid-pulse may add or drop an edge; set it while quiet
    always_ff @(posedge clk) begin
        if (rst)         tap <= `SRSC_TAP_RESET;
        else if (wr_tap) tap <= avs_writedata[3:0];
    end

    // Assertion counter; no software clear, saturates so wrap never rearms the skip
    // Masked assertions still count, keeping the index right when unmasked
    always_ff @(posedge clk) begin
        if (rst) begin
            assert_count <= 2'h0;
        end else if (sync_hit && assert_count != `SRSC_CNT_FULL) begin
            assert_count <= assert_count + 2'h1;
        end
    end

    // One-cycle reset pulses to divider, oscillators, filters, link
    // Only the selected source reaches here; the other is ignored
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse <= '0;
        end else begin
            pulse.div_reset  <= div_go;
            pulse.osc_reset  <= osc_go;
            pulse.filt_reset <= osc_go;
            pulse.lmfc_reset <= osc_go;
        end
    end

    // Local multiframe counter, realigned by an accepted assertion
    // Realign wins over the free-running wrap in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            lmfc_count <= 8'h00;
            lmfc_wrap  <= 1'b0;
        end else if (osc_go) begin
            lmfc_count <= 8'h00;
            lmfc_wrap  <= 1'b1;
        end else begin
            lmfc_count <= lmfc_end ? 8'h00 : lmfc_count + 8'h01;
            lmfc_wrap  <= lmfc_end;
        end
    end

    // Read decode
    // Registered when the request is taken, so it stands in the answer cycle
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (addr_hit(avs_address, `SRSC_ADDR_CTRL)) begin
            // Control bits as last written
            next_readdata[3:0] = ctrl;
        end else if (addr_hit(avs_address, `SRSC_ADDR_STATUS)) begin
            // Assertion index and multiframe phase
            next_readdata[1:0] = assert_count;
            next_readdata[15:8] = lmfc_count;
        end else if (addr_hit(avs_address, `SRSC_ADDR_TAP)) begin
            // Delay tap select
            next_readdata[3:0] = tap;
        end else if (addr_hit(avs_address, `SRSC_ADDR_RAW)) begin
            // Pin after synchroniser and after the taps
            next_readdata[0] = pin_sync;
            next_readdata[1] = pin_delayed;
        end else begin
            next_readdata = 32'h0000_0000; // Unmapped reads zero
        end
    end

    // Bus: waitrequest idles high, drops for one cycle to answer
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_state       <= SRSC_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            case (bus_state)
                SRSC_IDLE: begin
                    // Any request is taken; nothing is refused
                    if (avs_read | avs_write) begin
                        bus_state       <= SRSC_RESP;
                        avs_waitrequest <= 1'b0;
                        avs_readdata    <= next_readdata;
                    end
                end
                SRSC_RESP: begin
                    // Answer stands for exactly one cycle
                    bus_state       <= SRSC_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    // Unused code falls back to idle
                    bus_state       <= SRSC_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Outputs straight from flip-flops
    // No logic between these registers and the pins
    assign divider_reset    = pulse.div_reset;
    assign oscillator_reset = pulse.osc_reset;
    assign filter_reset     = pulse.filt_reset;
    assign lmfc_reset       = pulse.lmfc_reset;
    assign lmfc_boundary    = lmfc_wrap;
endmodule : srsc_top

// file: logic/srsc_cfg.svh
// Constants for the timing reference sync and reset control block
`ifndef SRSC_CFG_SVH
`define SRSC_CFG_SVH
`define SRSC_ADDR_CTRL      4'h0
`define SRSC_ADDR_STATUS    4'h1
`define SRSC_ADDR_TAP       4'h2
`define SRSC_ADDR_RAW       4'h3
`define SRSC_BIT_SW_ASSERT  0
`define SRSC_BIT_DIV_MASK   1
`define SRSC_BIT_OSC_MASK   2
`define SRSC_BIT_PIN_SEL    3
`define SRSC_CTRL_RESET     4'h8
`define SRSC_TAP_RESET      4'h0
`define SRSC_TAP_DEPTH      16
`define SRSC_CNT_FULL       2'h3
`define SRSC_CNT_LIMIT      2'h2
`define SRSC_LMFC_PERIOD    8'h20
`endif

// file: logic/srsc_pkg.sv
// Types for the timing reference sync and reset control block
package srsc_pkg;
    typedef struct packed {
        logic       pin_sel;
        logic       osc_mask;
        logic       div_mask;
        logic       sw_assert;
    } srsc_ctrl_type;
    typedef struct packed {
        logic       div_reset;
        logic       osc_reset;
        logic       filt_reset;
        logic       lmfc_reset;
    } srsc_pulse_type;
    typedef enum logic [1:0] {
        SRSC_IDLE = 2'b00,
        SRSC_RESP = 2'b01
    } srsc_bus_state_type;
endpackage : srsc_pkg

// file: logic/srsc_delay_line.sv
// Programmable tap delay line for the sampled reference
`timescale 1ns/1ps
`include "srsc_cfg.svh"
module srsc_delay_line (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       din,
    input  wire logic [3:0] tap,
    output logic            dout
);
    logic [`SRSC_TAP_DEPTH-1:0] stage; // Shift chain, one cycle each
    // Chain is a generate so the depth is set in one place
    genvar gi;
    generate
        for (gi = 0; gi < `SRSC_TAP_DEPTH; gi++) begin : g_stage
            if (gi == 0) begin : g_first
                always_ff @(posedge clk) begin
                    if (rst) stage[gi] <= 1'b0;
                    else     stage[gi] <= din;
                end
            end else begin : g_rest
                always_ff @(posedge clk) begin
                    if (rst) stage[gi] <= 1'b0;
                    else     stage[gi] <= stage[gi-1];
                end
            end
        end
    endgenerate
    // Registered tap select keeps the output on a flip-flop
    always_ff @(posedge clk) begin
        if (rst) dout <= 1'b0;
        else     dout <= stage[tap];
    end
endmodule : srsc_delay_line

// file: tb/srsc_ref_gen.sv
// Model of the external reference pulse generator
`timescale 1ns/1ps
module srsc_ref_gen #(parameter int GAP = 800) (
    input  wire logic clk,
    input  wire logic go,
    output wire logic pin,
    output wire logic busy
);
    int   cnt    = 0;     // Cycles since pulse start
    logic pin_q  = 1'b0;  // Pin idles low between shots
    logic busy_q = 1'b0;  // High from shot start to end of gap
    assign pin  = pin_q;
    assign busy = busy_q;
    // Four-cycle high pulse, then a quiet gap so the clock path can settle
    always @(posedge clk) begin
        if (go && !busy_q) begin
            busy_q <= 1'b1;
            cnt    <= 0;
        end else if (busy_q && cnt == GAP) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            cnt <= cnt + 1;
        end
        pin_q <= busy_q && cnt < 4;
    end
endmodule : srsc_ref_gen

// file: tb/srsc_checker.sv
// Checker of pulse grouping and bus timing at the block ports
`timescale 1ns/1ps
module srsc_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic divider_reset,
    input wire logic oscillator_reset,
    input wire logic filter_reset,
    input wire logic lmfc_reset,
    input wire logic lmfc_boundary
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_osc_group_same: assert property (oscillator_reset |-> filter_reset && lmfc_reset)
        else $error("oscillator pulse without its group");
    a_filter_with_osc: assert property (filter_reset |-> oscillator_reset)
        else $error("filter pulse alone");
    a_lmfc_with_osc: assert property (lmfc_reset |-> oscillator_reset)
        else $error("multiframe pulse alone");
    a_lmfc_align: assert property (lmfc_reset |-> lmfc_boundary)
        else $error("realign without boundary");
    a_lmfc_period: assert property (lmfc_boundary |-> ##[1:32] lmfc_boundary)
        else $error("multiframe boundary missing");
    a_div_single: assert property (divider_reset |=> !divider_reset)
        else $error("divider pulse too long");
    a_osc_single: assert property (oscillator_reset |=> !oscillator_reset)
        else $error("oscillator pulse too long");
    a_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer after one cycle");
    a_answer_once: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held too long");
    a_idle_wait: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without request");
endmodule : srsc_checker
bind srsc_top srsc_checker u_chk (.clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
    .divider_reset, .oscillator_reset, .filter_reset, .lmfc_reset, .lmfc_boundary);

// file: tb/tb_sysref_sync_reset_control.sv
// Self-checking bench of the sync reset block
`timescale 1ns/1ps
module tb_sysref_sync_reset_control;
    import srsc_pkg::*;
    logic clk, rst, go, avs_read, avs_write, avs_waitrequest, pin, busy;
    logic divider_reset, oscillator_reset, filter_reset, lmfc_reset, lmfc_boundary;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    int err_total = 0, checks_done = 0, seed = 94770, nref, ediv, eosc, div_n, osc_n;
    int since, seen_at;       // Cycles since start, and at divider pulse
    logic [3:0] tap_v;        // Tap written this round
    localparam int PIN_TO_PULSE = 5; // Sync 2, delay stage 1, delay output reg 1, pulse reg 1
    srsc_top DUT (.clk, .rst, .sync_ref_pin(pin), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .divider_reset, .oscillator_reset,
        .filter_reset, .lmfc_reset, .lmfc_boundary);
    srsc_ref_gen u_gen (.clk, .go, .pin, .busy);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Count reset pulses seen at the outputs
    always @(posedge clk) begin
        if (rst) begin
            div_n <= 0;
            osc_n <= 0;
        end else begin
            div_n <= div_n + (divider_reset === 1'b1);
            osc_n <= osc_n + (oscillator_reset === 1'b1);
        end
    end
    // Generator pin rises one cycle after go is taken
    always @(posedge clk) begin
        since <= go ? 0 : since + 1;
        if (divider_reset === 1'b1) seen_at <= since;
    end
    function automatic logic [31:0] exp_count(input int n);
        return (n > 3) ? 32'h3 : 32'(n);
    endfunction : exp_count
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (e !== g) begin
            err_total++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask : chk
    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    // Expected pulse totals for one accepted assertion
    task automatic expect_ref(input logic dm, input logic om);
        nref++;
        if (!dm) ediv++;
        if (!om && nref >= 3) eosc++;
    endtask : expect_ref
    task automatic fire(input logic dm, input logic om, input logic counts);
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (busy);
        if (counts) expect_ref(dm, om);
        chk(ediv, div_n);
        chk(eosc, osc_n);
    endtask : fire
    task automatic restart;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        {nref, ediv, eosc} = '0;
    endtask : restart
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        {go, avs_read, avs_write, avs_address, avs_writedata} = '0;
        rst = 1'b1;
        restart();
        fire(1'b0, 1'b0, 1'b1);
        bus(1'b0, 4'h0, '0);
        chk(32'h8, q);
        bus(1'b0, 4'hf, '0);
        chk(32'h0, q);
        // Tap 15 for the first pulse, then random per pulse; saturating count checked each time
        for (int i = 0; i < 4; i++) begin
            tap_v = (i == 0) ? 4'hf : 4'($random(seed));
            bus(1'b1, 4'h2, 32'(tap_v));
            bus(1'b0, 4'h2, '0);
            chk(32'(tap_v), q);
            fire(1'b0, 1'b0, 1'b1);
            chk(1 + PIN_TO_PULSE + tap_v, seen_at);
            bus(1'b0, 4'h1, '0);
            chk(exp_count(nref), q & 32'h3);
        end
        bus(1'b1, 4'h0, 32'ha);
        fire(1'b1, 1'b0, 1'b1);
        bus(1'b1, 4'h0, 32'hc);
        fire(1'b0, 1'b1, 1'b1);
        // Software source: pin is ignored, bit rise asserts
        bus(1'b1, 4'h0, 32'h0);
        fire(1'b0, 1'b0, 1'b0);
        bus(1'b1, 4'h0, 32'h1);
        repeat (10) @(posedge clk);
        expect_ref(1'b0, 1'b0);
        chk(ediv, div_n);
        chk(eosc, osc_n);
        restart();
        bus(1'b0, 4'h1, '0);
        chk(32'h0, q & 32'h3);
        fire(1'b0, 1'b0, 1'b1);
        chk(1 + PIN_TO_PULSE, seen_at);
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule : tb_sysref_sync_reset_control
